// file: dfpc_chan_if.sv
// dfpc_chan_if.sv: carrier between the register core and one fan channel.
// assumes the core drives cfg and the channel modules drive the rest.
`timescale 1ns/1ps
interface dfpc_chan_if;
  import dfpc_pkg::*;
  dfpc_cfg_s cfg;
  logic pin;
  logic tach_tick;
  modport core (output cfg, input pin, input tach_tick);
  modport pwm (input cfg, output pin);
  modport tach (input cfg, output tach_tick);
endinterface

// file: dfpc_fan_model.sv
// dfpc_fan_model.sv: fan drive stage that integrates the pwm pin level.
// assumes the pin is sampled on the rising edge of aclk.
`timescale 1ns/1ps
module dfpc_fan_model (
  // clock and pin
  input wire logic aclk,
  input wire logic pin
);
  // high cycles over a window of n clocks; phase does not matter
  task automatic count_high(input int n, output int hi);
    hi = 0;
    repeat (n) begin
      @(posedge aclk);
      if (pin === 1'b1) hi++;
    end
  endtask
endmodule // dfpc_fan_model

// file: dfpc_params.svh
// dfpc_params.svh: register indices, field positions, reset values,
// and step prescale counts for the dual fan pwm block.
// assumes plain inclusion by the package and by every design module.
`ifndef DFPC_PARAMS_SVH
`define DFPC_PARAMS_SVH
// register indices; byte address is four times the index
`define DFPC_IDX_FAN_ONE 10'h056
`define DFPC_IDX_FAN_TWO 10'h057
`define DFPC_IDX_CTL 10'h058
// reset values
`define DFPC_SPD_RST 8'h00
`define DFPC_CTL_RST 8'h50
// speed register fields
`define DFPC_FORCE_BIT 0
`define DFPC_DUTY_LO 1
`define DFPC_DUTY_W 6
`define DFPC_SEL_BIT 7
// shared control fields, fan two sits one or two bits higher
`define DFPC_SRC_LO 0
`define DFPC_DBL_LO 2
`define DFPC_TDIV_LO 4
// clocks per pwm step, indexed by {source select, clock select}
`define DFPC_PRESC_00 16'h030D
`define DFPC_PRESC_01 16'h0187
`define DFPC_PRESC_10 16'h001F
`define DFPC_PRESC_11 16'h0010
// axi response codes
`define DFPC_RESP_OKAY 2'h0
`define DFPC_RESP_SLVERR 2'h2
`endif

// file: dfpc_pkg.sv
// dfpc_pkg.sv: shared types of the dual fan pwm block.
// assumes dfpc_params.svh is on the include path.
`include "dfpc_params.svh"
package dfpc_pkg;
  typedef logic [7:0] dfpc_reg_t;
  typedef logic [`DFPC_DUTY_W-1:0] dfpc_duty_t;
  // per fan settings decoded from the registers
  typedef struct packed {
    logic force_hi;
    dfpc_duty_t duty;
    logic clk_sel;
    logic src_sel;
    logic dbl;
    logic [1:0] tach_div;
  } dfpc_cfg_s;
endpackage

// file: dfpc_pwm_chan.sv
// dfpc_pwm_chan.sv: one fan output, 64-step counter at a chosen rate.
// assumes settings arrive already synchronous to aclk.
`timescale 1ns/1ps
`include "dfpc_params.svh"
module dfpc_pwm_chan
  import dfpc_pkg::*;
(
  // clock and control
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // settings and pin
  dfpc_chan_if.pwm ch
);
  logic [15:0] base;
  logic [15:0] lim_m1;
  logic [15:0] pre_cnt_r;
  logic tick_r;
  dfpc_duty_t step_r;
  logic pin_r;
  logic duty_hi;

  // rate choice from clock select, source select and doubling
  assign base = ch.cfg.src_sel ?
    (ch.cfg.clk_sel ? `DFPC_PRESC_11 : `DFPC_PRESC_10) :
    (ch.cfg.clk_sel ? `DFPC_PRESC_01 : `DFPC_PRESC_00);
  assign lim_m1 = (ch.cfg.dbl ? {1'b0, base[15:1]} : base)
    - 16'h0001;
  assign duty_hi = step_r < ch.cfg.duty;
  assign ch.pin = pin_r;

  // step prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (ce) begin
      tick_r <= pre_cnt_r >= lim_m1;
      pre_cnt_r <= (pre_cnt_r >= lim_m1) ? 16'h0000 : pre_cnt_r + 16'h0001;
    end
  end

  // 64-step counter and pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_r <= '0;
      pin_r <= 1'b0;
    end else if (ce) begin
      if (tick_r) begin
        step_r <= step_r + 6'h01;
      end
      pin_r <= ch.cfg.force_hi | duty_hi;
    end
  end

  property p_force;
    @(posedge aclk) disable iff (!aresetn)
    ce && ch.cfg.force_hi |=> ch.pin;
  endproperty
  a_force: assert property (p_force) else $error("forced fan pin low");

  property p_zero;
    @(posedge aclk) disable iff (!aresetn)
    ce && !ch.cfg.force_hi && ch.cfg.duty == 6'h00 |=> !ch.pin;
  endproperty
  a_zero: assert property (p_zero) else $error("zero duty pin high");

  property p_last_low;
    @(posedge aclk) disable iff (!aresetn)
    ce && !ch.cfg.force_hi && step_r == 6'h3F |=> !ch.pin;
  endproperty
  a_last_low: assert property (p_last_low) else $error("step 63 high");

  property p_step;
    @(posedge aclk) disable iff (!aresetn)
    ce && tick_r |=> step_r == $past(step_r) + 6'h01;
  endproperty
  a_step: assert property (p_step) else $error("step did not advance");
endmodule // dfpc_pwm_chan

// file: dfpc_tach_scaler.sv
// dfpc_tach_scaler.sv: count clock enable for one tachometer counter.
// assumes the counter itself lives outside and uses tach_tick.
`timescale 1ns/1ps
`include "dfpc_params.svh"
module dfpc_tach_scaler
  import dfpc_pkg::*;
(
  // clock and control
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // settings and tick
  dfpc_chan_if.tach ch
);
  logic [2:0] lim;
  logic [2:0] cnt_r;
  logic tick_r;

  // divide by 1, 2, 4 or 8
  assign lim = 3'((4'h1 << ch.cfg.tach_div) - 4'h1);
  assign ch.tach_tick = tick_r;

  // divider counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 3'h0;
      tick_r <= 1'b0;
    end else if (ce) begin
      tick_r <= cnt_r >= lim;
      cnt_r <= (cnt_r >= lim) ? 3'h0 : cnt_r + 3'h1;
    end
  end

  property p_div1;
    @(posedge aclk) disable iff (!aresetn)
    ce && ch.cfg.tach_div == 2'h0 |=> tick_r;
  endproperty
  a_div1: assert property (p_div1) else $error("div 1 missed tick");

  sequence s_div2_run;
    (ce && ch.cfg.tach_div == 2'h1 && tick_r) ##1
    (ce && ch.cfg.tach_div == 2'h1);
  endsequence
  property p_div2;
    @(posedge aclk) disable iff (!aresetn)
    s_div2_run |-> !tick_r ##1 tick_r;
  endproperty
  a_div2: assert property (p_div2) else $error("div 2 spacing");

  sequence s_div8_run;
    (ce && ch.cfg.tach_div == 2'h3 && tick_r) ##1
    (ce && ch.cfg.tach_div == 2'h3)[*7];
  endsequence
  property p_div8;
    @(posedge aclk) disable iff (!aresetn)
    s_div8_run |=> tick_r;
  endproperty
  a_div8: assert property (p_div8) else $error("div 8 spacing");
endmodule // dfpc_tach_scaler

// file: dfpc_top.sv
// dfpc_top.sv: dual fan pwm control, axi4-lite registers and two channels.
// assumes a single 50 MHz aclk and a synchronous active-low reset.
//
// Operation
// - force bit set holds the fan pin high, else duty field rules
// - six-bit duty sets high steps; zero low, 32 half, 63 high 1 low
// - fan one rate from its clock select, source select, doubling bit
// - fan one doubling bit 2 set doubles the selected rate
// - fan two doubling bit 3 set doubles the selected rate
// - fan two speed register matches fan one layout and behaviour
// - fan two rate from its bit 7, control bits 1 and 3
// - control bits 5:4 scale fan one tach clock; 00 by 1, 01 by 2
// - tach divisor code 10 divides by 4, code 11 by 8
// - control bits 7:6 scale fan two tach clock, same codes
// - reset clears both speed registers and loads control with 0x50
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "dfpc_params.svh"
module dfpc_top
  import dfpc_pkg::*;
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // fan pins and tach count enables
  output logic first_fan_output,
  output logic second_fan_output,
  output logic first_fan_tach_tick,
  output logic second_fan_tach_tick
);
  // register storage
  dfpc_reg_t spd_r [2];
  dfpc_reg_t ctl_r;

  // write channel state
  logic aw_full_r;
  logic w_full_r;
  logic [9:0] aw_idx_r;
  logic [7:0] w_data_r;
  logic w_strb0_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  // read channel state
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // handshakes and next values
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_wr;
  logic aw_full_nxt;
  logic w_full_nxt;
  logic bvalid_nxt;
  logic rvalid_nxt;

  // write decode
  logic wr_one;
  logic wr_two;
  logic wr_ctl;
  logic wr_hit;

  // read decode
  logic [9:0] rd_idx;
  logic rd_one;
  logic rd_two;
  logic rd_ctl;
  logic rd_hit;
  logic [7:0] rd_val;

  // channel carriers
  dfpc_chan_if ch [2] ();

  // handshake terms
  assign aw_hs = s_axi_awvalid & awready_r;
  assign w_hs = s_axi_wvalid & wready_r;
  assign ar_hs = s_axi_arvalid & arready_r;
  assign do_wr = aw_full_r & w_full_r;

  // holding and response next state
  assign aw_full_nxt = (aw_full_r | aw_hs) & ~do_wr;
  assign w_full_nxt = (w_full_r | w_hs) & ~do_wr;
  assign bvalid_nxt = do_wr | (bvalid_r & ~s_axi_bready);
  assign rvalid_nxt = ar_hs | (rvalid_r & ~s_axi_rready);

  // write address decode on the held word index
  assign wr_one = aw_idx_r == `DFPC_IDX_FAN_ONE;
  assign wr_two = aw_idx_r == `DFPC_IDX_FAN_TWO;
  assign wr_ctl = aw_idx_r == `DFPC_IDX_CTL;
  assign wr_hit = wr_one | wr_two | wr_ctl;

  // read address decode and data select
  assign rd_idx = s_axi_araddr[11:2];
  assign rd_one = rd_idx == `DFPC_IDX_FAN_ONE;
  assign rd_two = rd_idx == `DFPC_IDX_FAN_TWO;
  assign rd_ctl = rd_idx == `DFPC_IDX_CTL;
  assign rd_hit = rd_one | rd_two | rd_ctl;
  assign rd_val = rd_one ? spd_r[0] :
                  rd_two ? spd_r[1] :
                  rd_ctl ? ctl_r : 8'h00;

  // bus outputs straight from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // write address and data holding, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_idx_r <= 10'h000;
      w_data_r <= 8'h00;
      w_strb0_r <= 1'b0;
    end else if (ce) begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      if (aw_hs) begin
        aw_idx_r <= s_axi_awaddr[11:2];
      end
      if (w_hs) begin
        w_data_r <= s_axi_wdata[7:0];
        w_strb0_r <= s_axi_wstrb[0];
      end
    end
  end

  // write ready and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `DFPC_RESP_OKAY;
    end else if (ce) begin
      awready_r <= ~aw_full_nxt & ~bvalid_nxt;
      wready_r <= ~w_full_nxt & ~bvalid_nxt;
      bvalid_r <= bvalid_nxt;
      if (do_wr) begin
        bresp_r <= wr_hit ? `DFPC_RESP_OKAY : `DFPC_RESP_SLVERR;
      end
    end
  end

  // register writes, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spd_r[0] <= `DFPC_SPD_RST;
      spd_r[1] <= `DFPC_SPD_RST;
      ctl_r <= `DFPC_CTL_RST;
    end else if (ce && do_wr && w_strb0_r) begin
      if (wr_one) begin
        spd_r[0] <= w_data_r;
      end
      if (wr_two) begin
        spd_r[1] <= w_data_r;
      end
      if (wr_ctl) begin
        ctl_r <= w_data_r;
      end
    end
  end

  // read channel, one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `DFPC_RESP_OKAY;
    end else if (ce) begin
      arready_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_hs) begin
        rdata_r <= {24'h000000, rd_val};
        rresp_r <= rd_hit ? `DFPC_RESP_OKAY : `DFPC_RESP_SLVERR;
      end
    end
  end

  // per fan settings and channel instances
  for (genvar g = 0; g < 2; g++) begin : g_fan
    assign ch[g].cfg.force_hi = spd_r[g][`DFPC_FORCE_BIT];
    assign ch[g].cfg.duty =
      spd_r[g][`DFPC_DUTY_LO +: `DFPC_DUTY_W];
    assign ch[g].cfg.clk_sel = spd_r[g][`DFPC_SEL_BIT];
    assign ch[g].cfg.src_sel = ctl_r[`DFPC_SRC_LO + g];
    assign ch[g].cfg.dbl = ctl_r[`DFPC_DBL_LO + g];
    assign ch[g].cfg.tach_div =
      ctl_r[`DFPC_TDIV_LO + 2 * g +: 2];

    dfpc_pwm_chan u_pwm (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .ch(ch[g])
    );

    dfpc_tach_scaler u_tach (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .ch(ch[g])
    );
  end

  // pins and ticks from channel flops
  assign first_fan_output = ch[0].pin;
  assign second_fan_output = ch[1].pin;
  assign first_fan_tach_tick = ch[0].tach_tick;
  assign second_fan_tach_tick = ch[1].tach_tick;

  property p_rst;
    @(posedge aclk)
    !aresetn |=> spd_r[0] == `DFPC_SPD_RST &&
      spd_r[1] == `DFPC_SPD_RST && ctl_r == `DFPC_CTL_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");

  sequence s_ctl_write;
    ce && do_wr && wr_ctl && w_strb0_r;
  endsequence
  property p_ctl_write;
    @(posedge aclk) disable iff (!aresetn)
    s_ctl_write |=> ctl_r == $past(w_data_r) && bvalid_r &&
      ch[0].cfg.tach_div == $past(w_data_r[5:4]);
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("control write lost");

  property p_ctl_read;
    @(posedge aclk) disable iff (!aresetn)
    ce && ar_hs && rd_ctl |=> rvalid_r &&
      rdata_r == {24'h000000, $past(ctl_r)} && rresp_r == `DFPC_RESP_OKAY;
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("control read wrong");

  // fan two write reaches its register and its channel settings
  sequence s_two_write;
    ce && do_wr && wr_two && w_strb0_r;
  endsequence
  property p_two_write;
    @(posedge aclk) disable iff (!aresetn)
    s_two_write |=> spd_r[1] == $past(w_data_r) &&
      ch[1].cfg.duty == $past(w_data_r[`DFPC_DUTY_LO +: `DFPC_DUTY_W]) &&
      ch[1].cfg.clk_sel == $past(w_data_r[`DFPC_SEL_BIT]);
  endproperty
  a_two_write: assert property (p_two_write)
    else $error("fan two write lost");

  // unmapped write changes nothing and answers with an error
  property p_refused_wr;
    @(posedge aclk) disable iff (!aresetn)
    ce && do_wr && !wr_hit |=> bresp_r == `DFPC_RESP_SLVERR &&
      spd_r[0] == $past(spd_r[0]) && spd_r[1] == $past(spd_r[1]) &&
      ctl_r == $past(ctl_r);
  endproperty
  a_refused_wr: assert property (p_refused_wr)
    else $error("unmapped write took effect");

  // pins and ticks idle low out of reset
  property p_pin_rst;
    @(posedge aclk)
    !aresetn |=> !first_fan_output && !second_fan_output &&
      !first_fan_tach_tick && !second_fan_tach_tick;
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("fan outputs not low after reset");
endmodule // dfpc_top

// file: dfpc_top_bench.sv
// dfpc_top_bench.sv: self-checking bench for the dual fan pwm block.
// assumes a 50 MHz aclk and the two fan models on the output pins.
`timescale 1ns/1ps
`include "dfpc_params.svh"
module dfpc_top_bench;
  import dfpc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000, a;
  logic [31:0] wdata = 32'h0, r;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic fan_one_speed, fan_two_speed, tick1, tick2;
  int n_mismatch = 0, n_tests = 0, t1, t2;
  int base[4] = '{`DFPC_PRESC_00, `DFPC_PRESC_01, `DFPC_PRESC_10,
                  `DFPC_PRESC_11};
  logic [33:0] rd_q[$], e;
  logic [1:0] wr_q[$];

  dfpc_top uut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .first_fan_output(fan_one_speed),
    .second_fan_output(fan_two_speed), .first_fan_tach_tick(tick1),
    .second_fan_tach_tick(tick2));
  dfpc_fan_model m1 (.aclk(aclk), .pin(fan_one_speed));
  dfpc_fan_model m2 (.aclk(aclk), .pin(fan_two_speed));

  // free running clock
  always #10 aclk = ~aclk;

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // write: both channels offered, each dropped at its own ready
  task automatic wr(input logic [11:0] ad, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    wr_q.push_back(er);
    @(posedge aclk);
    awaddr <= ad;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
  endtask

  // read: expected word and response noted before the request
  task automatic rd(input logic [11:0] ad, input logic [31:0] ed,
                    input logic [1:0] er);
    rd_q.push_back({er, ed});
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b0;
  endtask

  // program both fans, let the rates settle, integrate each pin
  task automatic run_cfg(input logic [7:0] c, input logic [7:0] s1,
                         input logic [7:0] s2);
    logic [7:0] s;
    int n;
    int hi;
    wr(12'h160, {24'h0, c}, 4'h1, 2'h0);
    wr(12'h158, {24'h0, s1}, 4'h1, 2'h0);
    wr(12'h15C, {24'h0, s2}, 4'h1, 2'h0);
    repeat (2100) @(posedge aclk);
    for (int k = 0; k < 2; k++) begin
      s = k ? s2 : s1;
      n = base[{c[k], s[7]}] >> c[2 + k];
      if (k == 0) m1.count_high(64 * n, hi);
      else m2.count_high(64 * n, hi);
      check("fan pin", hi, s[0] ? 64 * n : n * s[6:1]);
    end
  endtask

  // response monitor takes the oldest note for each answer
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      e = rd_q.pop_front();
      check("rdata", rdata, e[31:0]);
      check("rresp", {30'h0, rresp}, {30'h0, e[33:32]});
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      check("bresp", {30'h0, bresp}, {30'h0, wr_q.pop_front()});
    end
  end

  // main sequence
  initial begin
    void'($urandom(32'h2822));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h158, 32'h0, 2'h0);
    rd(12'h15C, 32'h0, 2'h0);
    rd(12'h160, 32'h50, 2'h0);
    rd(12'h164, 32'h0, 2'h2);
    wr(12'h164, 32'hFF, 4'h1, 2'h2);
    for (int i = 0; i < 3; i++) begin
      r = $urandom();
      a = 12'h158 + 12'(4 * i);
      wr(a, r, 4'h1, 2'h0);
      rd(a, {24'h0, r[7:0]}, 2'h0);
      wr(a, ~r, 4'h0, 2'h0);
      rd(a, {24'h0, r[7:0]}, 2'h0);
    end
    run_cfg(8'h53, 8'hC0, 8'h02);
    run_cfg(8'h5F, 8'h7E, 8'hC0);
    run_cfg(8'h57, 8'h8B, 8'h80);
    run_cfg(8'h5B, 8'hFE, 8'h01);
    run_cfg(8'h5C, 8'h9A, 8'h40);
    for (int c = 0; c < 4; c++) begin
      wr(12'h160, {24'h0, 2'(3 - c), 2'(c), 4'h0}, 4'h1, 2'h0);
      repeat (16) @(posedge aclk);
      t1 = 0;
      t2 = 0;
      repeat (64) begin
        @(posedge aclk);
        t1 += (tick1 === 1'b1);
        t2 += (tick2 === 1'b1);
      end
      check("tick one", t1, 64 >> c);
      check("tick two", t2, 64 >> (3 - c));
    end
    // clock enable low freezes pin and ticks
    ce <= 1'b0;
    @(posedge aclk);
    a = {9'h0, fan_one_speed, tick1, tick2};
    t1 = 0;
    repeat (20) begin
      @(posedge aclk);
      t1 += ({fan_one_speed, tick1, tick2} !== a[2:0]);
    end
    ce <= 1'b1;
    check("frozen outputs", t1, 0);
    stop_test();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (80000) @(posedge aclk);
    n_mismatch++;
    stop_test();
  end
endmodule // dfpc_top_bench
